// >>> acp_cmd_ctrl.sv
// configuration, seek range and power command interpreter of the task file
`timescale 1ns/10ps
`default_nettype none
module acp_cmd_ctrl #(
    parameter int IDLE_CYC = acp_pkg::IDLE_SLEEP_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic hw_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic busy,
    output logic intrq,
    output logic byte_mode,
    output logic iois16_en,
    output logic lookahead_en,
    output logic long_ecc4,
    output logic multi_en,
    output logic [7:0] multi_count,
    output logic asleep
);
    // task file
    logic [7:0] feat_ff, cnt_ff, sec_ff, tlo_ff, thi_ff, dh_ff;
    logic [7:0] nxt_feat, nxt_cnt, nxt_sec, nxt_tlo, nxt_thi, nxt_dh;
    logic [7:0] opc_ff, nxt_opc;
    // configuration
    logic byte_ff, nxt_byte, look_ff, nxt_look, ecc_ff, nxt_ecc;
    logic keep_ff, nxt_keep, men_ff, nxt_men, sleep_ff, nxt_sleep;
    logic [7:0] mcnt_ff, nxt_mcnt;
    logic [3:0] heads_ff, nxt_heads;
    logic [7:0] spt_ff, nxt_spt;
    // status
    logic err_ff, nxt_err, irq_ff, nxt_irq;
    logic [7:0] errreg_ff, nxt_errreg, ext_ff, nxt_ext, rdata_ff, nxt_rdata;
    logic [3:0] bcnt_ff, nxt_bcnt;
    acp_pkg::acp_state_e st_ff, nxt_st;
    logic oor, timer_exp, cmd_wr, defaults;
    logic busy_ff, nxt_busy, iois_ff, nxt_iois;

    acp_range_chk u_range (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .lba_mode(dh_ff[acp_pkg::DRV_LBA_BIT]),
        .head(dh_ff[3:0]),
        .cyl({thi_ff, tlo_ff}),
        .sector(sec_ff),
        .max_head(heads_ff),
        .max_sector(spt_ff),
        .max_cyl(acp_pkg::DFLT_CYLS),
        .lba_limit(acp_pkg::DFLT_LBA_MAX),
        .out_of_range(oor)
    );

    acp_idle_timer #(.IDLE_CYC(IDLE_CYC)) u_idle (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .restart(reg_wr || reg_rd),
        .hold(st_ff != acp_pkg::ACP_IDLE || sleep_ff),
        .expired(timer_exp)
    );

    // opcode writes while busy are ignored
    assign cmd_wr = reg_wr && reg_addr == acp_pkg::OFF_OPCODE
        && st_ff == acp_pkg::ACP_IDLE;
    // soft reset restores only when allowed
    assign defaults = hw_rst || (soft_rst && !keep_ff);

    always_comb begin
        nxt_feat = feat_ff;
        nxt_cnt = cnt_ff;
        nxt_sec = sec_ff;
        nxt_tlo = tlo_ff;
        nxt_thi = thi_ff;
        nxt_dh = dh_ff;
        nxt_opc = opc_ff;
        if (reg_wr && st_ff == acp_pkg::ACP_IDLE) begin
            case (reg_addr)
                acp_pkg::OFF_FEATURE: nxt_feat = reg_wdata;
                acp_pkg::OFF_COUNT: nxt_cnt = reg_wdata;
                acp_pkg::OFF_SECTOR: nxt_sec = reg_wdata;
                acp_pkg::OFF_TRK_LO: nxt_tlo = reg_wdata;
                acp_pkg::OFF_TRK_HI: nxt_thi = reg_wdata;
                acp_pkg::OFF_DRV_HEAD: nxt_dh = reg_wdata;
                acp_pkg::OFF_OPCODE: nxt_opc = reg_wdata;
                default: nxt_opc = opc_ff;
            endcase
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_bcnt = bcnt_ff;
        nxt_byte = byte_ff;
        nxt_look = look_ff;
        nxt_ecc = ecc_ff;
        nxt_keep = keep_ff;
        nxt_men = men_ff;
        nxt_mcnt = mcnt_ff;
        nxt_heads = heads_ff;
        nxt_spt = spt_ff;
        nxt_sleep = sleep_ff;
        nxt_err = err_ff;
        nxt_errreg = errreg_ff;
        nxt_ext = ext_ff;
        nxt_irq = irq_ff;
        // reading status acknowledges the interrupt
        if (reg_rd && reg_addr == acp_pkg::OFF_STATUS) begin
            nxt_irq = 1'b0;
        end
        case (st_ff)
            acp_pkg::ACP_IDLE: begin
                if (timer_exp) begin
                    nxt_sleep = 1'b1;
                end
                if (cmd_wr) begin
                    // any new command wakes the device
                    nxt_sleep = 1'b0;
                    nxt_err = 1'b0;
                    nxt_errreg = acp_pkg::ZERO8;
                    nxt_ext = acp_pkg::EXT_NONE;
                    nxt_irq = 1'b0;
                    nxt_bcnt = acp_pkg::BUSY_CYC;
                    nxt_st = acp_pkg::ACP_BUSY;
                end
            end
            acp_pkg::ACP_BUSY: begin
                if (bcnt_ff == 4'h0) begin
                    nxt_st = acp_pkg::ACP_EXEC;
                end else begin
                    nxt_bcnt = bcnt_ff - 4'h1;
                end
            end
            acp_pkg::ACP_EXEC: begin
                nxt_st = acp_pkg::ACP_DONE;
                if (opc_ff[7:4] == acp_pkg::OPC_SEEK_HI) begin
                    // range check only, no media action
                    if (oor) begin
                        nxt_err = 1'b1;
                        nxt_errreg = acp_pkg::ERR_IDNF;
                        nxt_ext = acp_pkg::EXT_BAD_ADDR;
                    end
                end else begin
                    case (opc_ff)
                        acp_pkg::OPC_SET_FEAT: begin
                            case (feat_ff)
                                acp_pkg::FEAT_BYTE_ON: nxt_byte = 1'b1;
                                acp_pkg::FEAT_BYTE_OFF: nxt_byte = 1'b0;
                                acp_pkg::FEAT_LOOKAHEAD_OFF: nxt_look = 1'b0;
                                acp_pkg::FEAT_LONG_ECC: nxt_ecc = 1'b1;
                                acp_pkg::FEAT_KEEP_ON_SOFT: nxt_keep = 1'b1;
                                acp_pkg::FEAT_RESTORE_ON_SOFT: nxt_keep = 1'b0;
                                acp_pkg::FEAT_NOP_A, acp_pkg::FEAT_NOP_B,
                                acp_pkg::FEAT_NOP_C: nxt_keep = keep_ff;
                                default: begin
                                    nxt_err = 1'b1;
                                    nxt_errreg = acp_pkg::ERR_ABORT;
                                    nxt_ext = acp_pkg::EXT_ABORTED;
                                end
                            endcase
                        end
                        acp_pkg::OPC_SET_MULT: begin
                            if (cnt_ff == acp_pkg::SUPPORTED_BLOCK) begin
                                nxt_mcnt = cnt_ff;
                                nxt_men = 1'b1;
                            end else if (cnt_ff == acp_pkg::ZERO8) begin
                                nxt_men = 1'b0;
                                nxt_mcnt = acp_pkg::ZERO8;
                            end else begin
                                nxt_men = 1'b0;
                                nxt_mcnt = acp_pkg::ZERO8;
                                nxt_err = 1'b1;
                                nxt_errreg = acp_pkg::ERR_ABORT;
                                nxt_ext = acp_pkg::EXT_ABORTED;
                            end
                        end
                        acp_pkg::OPC_SLEEP_A, acp_pkg::OPC_SLEEP_B,
                        acp_pkg::OPC_STBY_A, acp_pkg::OPC_STBY_B,
                        acp_pkg::OPC_STBYI_A, acp_pkg::OPC_STBYI_B: begin
                            nxt_sleep = 1'b1;
                        end
                        default: begin
                            // other opcodes belong to other handlers
                            nxt_err = 1'b1;
                            nxt_errreg = acp_pkg::ERR_ABORT;
                            nxt_ext = acp_pkg::EXT_ABORTED;
                        end
                    endcase
                end
            end
            acp_pkg::ACP_DONE: begin
                // busy drops now, interrupt raised with it
                nxt_irq = 1'b1;
                nxt_st = acp_pkg::ACP_IDLE;
            end
            default: nxt_st = acp_pkg::ACP_IDLE;
        endcase
        if (defaults) begin
            nxt_byte = 1'b0;
            nxt_men = 1'b0;
            nxt_mcnt = acp_pkg::ZERO8;
            nxt_heads = acp_pkg::DFLT_HEADS;
            nxt_spt = acp_pkg::DFLT_SECTORS;
            nxt_look = 1'b0;
            nxt_ecc = 1'b1;
        end
        if (hw_rst || soft_rst) begin
            nxt_st = acp_pkg::ACP_IDLE;
            nxt_irq = 1'b0;
            nxt_sleep = 1'b0;
        end
        // the keep flag itself only returns on hardware reset
        if (hw_rst) begin
            nxt_keep = 1'b0;
        end
        // pins follow the next state so they leave flops directly
        nxt_busy = (nxt_st != acp_pkg::ACP_IDLE);
        nxt_iois = !nxt_byte;
    end

    always_comb begin
        nxt_rdata = acp_pkg::ZERO8;
        if (reg_rd) begin
            case (reg_addr)
                acp_pkg::OFF_EXT_ERR: nxt_rdata = ext_ff;
                acp_pkg::OFF_ERROR: nxt_rdata = errreg_ff;
                acp_pkg::OFF_COUNT: nxt_rdata = cnt_ff;
                acp_pkg::OFF_SECTOR: nxt_rdata = sec_ff;
                acp_pkg::OFF_TRK_LO: nxt_rdata = tlo_ff;
                acp_pkg::OFF_TRK_HI: nxt_rdata = thi_ff;
                acp_pkg::OFF_DRV_HEAD: nxt_rdata = dh_ff;
                acp_pkg::OFF_STATUS: begin
                    nxt_rdata[acp_pkg::ST_BSY] = (st_ff != acp_pkg::ACP_IDLE);
                    nxt_rdata[acp_pkg::ST_DRDY] = (st_ff == acp_pkg::ACP_IDLE);
                    nxt_rdata[acp_pkg::ST_ERR] = err_ff;
                end
                default: nxt_rdata = acp_pkg::ZERO8;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            feat_ff <= 8'h00;
            cnt_ff <= acp_pkg::RST_COUNT;
            sec_ff <= acp_pkg::RST_SECTOR;
            tlo_ff <= 8'h00;
            thi_ff <= 8'h00;
            dh_ff <= acp_pkg::RST_DRV_HEAD;
            opc_ff <= 8'h00;
            st_ff <= acp_pkg::ACP_IDLE;
            bcnt_ff <= 4'h0;
            byte_ff <= 1'b0;
            look_ff <= 1'b0;
            ecc_ff <= 1'b1;
            keep_ff <= 1'b0;
            men_ff <= 1'b0;
            mcnt_ff <= 8'h00;
            heads_ff <= acp_pkg::DFLT_HEADS;
            spt_ff <= acp_pkg::DFLT_SECTORS;
            sleep_ff <= 1'b0;
            err_ff <= 1'b0;
            errreg_ff <= 8'h00;
            ext_ff <= 8'h00;
            irq_ff <= 1'b0;
            rdata_ff <= 8'h00;
            busy_ff <= 1'b0;
            iois_ff <= 1'b1;
        end else begin
            feat_ff <= nxt_feat;
            cnt_ff <= nxt_cnt;
            sec_ff <= nxt_sec;
            tlo_ff <= nxt_tlo;
            thi_ff <= nxt_thi;
            dh_ff <= nxt_dh;
            opc_ff <= nxt_opc;
            st_ff <= nxt_st;
            bcnt_ff <= nxt_bcnt;
            byte_ff <= nxt_byte;
            look_ff <= nxt_look;
            ecc_ff <= nxt_ecc;
            keep_ff <= nxt_keep;
            men_ff <= nxt_men;
            mcnt_ff <= nxt_mcnt;
            heads_ff <= nxt_heads;
            spt_ff <= nxt_spt;
            sleep_ff <= nxt_sleep;
            err_ff <= nxt_err;
            errreg_ff <= nxt_errreg;
            ext_ff <= nxt_ext;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
            busy_ff <= nxt_busy;
            iois_ff <= nxt_iois;
        end
    end

    // every output is a flop
    assign reg_rdata = rdata_ff;
    assign busy = busy_ff;
    assign intrq = irq_ff;
    assign byte_mode = byte_ff;
    assign iois16_en = iois_ff;
    assign lookahead_en = look_ff;
    assign long_ecc4 = ecc_ff;
    assign multi_en = men_ff;
    assign multi_count = mcnt_ff;
    assign asleep = sleep_ff;
endmodule
`default_nettype wire

// >>> acp_cmd_ctrl_sva.sv
// assertion checker for the command handler ports
`timescale 1ns/10ps
`default_nettype none
module acp_cmd_ctrl_chk #(
    parameter int IDLE_CYC = acp_pkg::IDLE_SLEEP_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic hw_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic busy,
    input wire logic intrq,
    input wire logic byte_mode,
    input wire logic iois16_en,
    input wire logic lookahead_en,
    input wire logic long_ecc4,
    input wire logic multi_en,
    input wire logic [7:0] multi_count,
    input wire logic asleep
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic opc_wr;
    assign opc_wr = reg_wr && reg_addr == acp_pkg::OFF_OPCODE && !busy && !soft_rst && !hw_rst;
    property p_iois; iois16_en == !byte_mode; endproperty
    a_iois: assert property (p_iois) else $error("iois16 not inverse of byte mode");
    property p_dflt; !lookahead_en && long_ecc4; endproperty
    a_dflt: assert property (p_dflt) else $error("look-ahead or ecc setting moved");
    property p_busy_rise; opc_wr |=> busy; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");
    property p_busy_len; $rose(busy) |-> busy[*4] ##[1:4] !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_done_intr; $fell(busy) && !$past(hw_rst) && !$past(soft_rst) |-> intrq; endproperty
    a_done_intr: assert property (p_done_intr) else $error("no interrupt at end");
    property p_intr_src; $rose(intrq) |-> $fell(busy); endproperty
    a_intr_src: assert property (p_intr_src) else $error("interrupt not at busy fall");
    property p_multi; multi_count == (multi_en ? acp_pkg::SUPPORTED_BLOCK : acp_pkg::ZERO8);
    endproperty
    a_multi: assert property (p_multi) else $error("block count mismatch");
    property p_hw; hw_rst |=> !multi_en && !byte_mode && !asleep && !intrq; endproperty
    a_hw: assert property (p_hw) else $error("hardware reset left state");
    property p_wake; asleep && opc_wr |-> ##[1:8] !asleep; endproperty
    a_wake: assert property (p_wake) else $error("command did not wake");
    c_mult: cover property (opc_wr && reg_wdata == acp_pkg::OPC_SET_MULT);
    c_auto: cover property ($rose(asleep) && !busy);
    c_byte: cover property ($rose(byte_mode));
endmodule
bind acp_cmd_ctrl acp_cmd_ctrl_chk #(.IDLE_CYC(IDLE_CYC)) u_chk (.core_clk(core_clk),
    .sys_rst(sys_rst), .soft_rst(soft_rst), .hw_rst(hw_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy), .intrq(intrq), .byte_mode(byte_mode), .iois16_en(iois16_en),
    .lookahead_en(lookahead_en), .long_ecc4(long_ecc4), .multi_en(multi_en),
    .multi_count(multi_count), .asleep(asleep));
`default_nettype wire

// >>> acp_cmd_ctrl_tb.sv
// self-checking bench of the command handler
`timescale 1ns/10ps
`default_nettype none
module acp_cmd_ctrl_tb;
    localparam int IDLE = 20;
    logic core_clk, sys_rst, soft_rst, hw_rst, reg_wr, reg_rd, busy, intrq, asleep;
    logic byte_mode, iois16_en, lookahead_en, long_ecc4, multi_en;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, multi_count, st;
    int error_cnt = 0;
    int checked = 0;
    acp_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    acp_cmd_ctrl #(.IDLE_CYC(IDLE)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .soft_rst(soft_rst), .hw_rst(hw_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .intrq(intrq),
        .byte_mode(byte_mode), .iois16_en(iois16_en), .lookahead_en(lookahead_en),
        .long_ecc4(long_ecc4), .multi_en(multi_en), .multi_count(multi_count),
        .asleep(asleep));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    // opcode write, bounded wait for completion, status read
    task automatic cmd(input logic [7:0] op, input logic err);
        int n;
        host.wr(acp_pkg::OFF_OPCODE, op);
        chk("busy", busy, 8'h01);
        n = 0;
        while (busy !== 1'b0 && n < 30) begin
            tick();
            n++;
        end
        if (busy !== 1'b0) begin
            error_cnt++;
            conclude();
        end
        chk("intrq", intrq, 8'h01);
        host.rd(acp_pkg::OFF_STATUS, st);
        chk("err bit", st[acp_pkg::ST_ERR], err);
        chk("intrq clear", intrq, 8'h00);
    endtask
    task automatic feat(input logic [7:0] code, input logic err);
        host.wr(acp_pkg::OFF_FEATURE, code);
        cmd(acp_pkg::OPC_SET_FEAT, err);
    endtask
    task automatic mult(input logic [7:0] cnt, input logic err);
        host.wr(acp_pkg::OFF_COUNT, cnt);
        cmd(acp_pkg::OPC_SET_MULT, err);
    endtask
    task automatic pulse(input logic hw);
        @(posedge core_clk);
        hw_rst <= hw;
        soft_rst <= !hw;
        @(posedge core_clk);
        hw_rst <= 1'b0;
        soft_rst <= 1'b0;
        #1;
    endtask
    task automatic t_dflt;
        chk("byte", byte_mode, 8'h00);
        chk("iois", iois16_en, 8'h01);
        chk("lookahead", lookahead_en, 8'h00);
        chk("ecc4", long_ecc4, 8'h01);
        chk("multi", {multi_en, multi_count[6:0]}, 8'h00);
    endtask
    task automatic t_feat;
        logic [7:0] quiet [5] = '{8'h55, 8'hbb, 8'h69, 8'h96, 8'h9a};
        foreach (quiet[i]) begin
            feat(quiet[i], 1'b0);
            chk("cfg", {byte_mode, lookahead_en, long_ecc4}, 8'h01);
        end
        feat(acp_pkg::FEAT_BYTE_ON, 1'b0);
        chk("iois off", {byte_mode, iois16_en}, 8'h02);
        feat(8'h42, 1'b1);
        host.rd(acp_pkg::OFF_ERROR, st);
        chk("abort", st, acp_pkg::ERR_ABORT);
        chk("byte kept", byte_mode, 8'h01);
        feat(acp_pkg::FEAT_BYTE_OFF, 1'b0);
        chk("iois on", {byte_mode, iois16_en}, 8'h01);
    endtask
    task automatic t_mult;
        mult(8'h01, 1'b0);
        chk("multi on", {multi_en, multi_count[6:0]}, 8'h81);
        mult(8'h00, 1'b0);
        chk("multi zero", multi_en, 8'h00);
        mult(8'h01, 1'b0);
        mult(8'h02, 1'b1);
        host.rd(acp_pkg::OFF_ERROR, st);
        chk("size abort", st, acp_pkg::ERR_ABORT);
        chk("multi off", multi_en, 8'h00);
    endtask
    task automatic t_seek;
        host.wr(acp_pkg::OFF_DRV_HEAD, 8'ha0);
        host.wr(acp_pkg::OFF_TRK_HI, 8'h00);
        host.wr(acp_pkg::OFF_TRK_LO, 8'h00);
        host.wr(acp_pkg::OFF_SECTOR, 8'h01);
        cmd(8'h70, 1'b0);
        host.wr(acp_pkg::OFF_TRK_HI, 8'hff);
        cmd(8'h7f, 1'b1);
        host.rd(acp_pkg::OFF_EXT_ERR, st);
        chk("ext err", st, acp_pkg::EXT_BAD_ADDR);
        host.rd(acp_pkg::OFF_ERROR, st);
        chk("range err", st, acp_pkg::ERR_IDNF);
        // lba mode: cylinder ff00 lies past the limit, zero does not
        host.wr(acp_pkg::OFF_DRV_HEAD, 8'he0);
        cmd(8'h75, 1'b1);
        host.wr(acp_pkg::OFF_TRK_HI, 8'h00);
        cmd(8'h70, 1'b0);
    endtask
    task automatic t_resets;
        feat(acp_pkg::FEAT_BYTE_ON, 1'b0);
        mult(8'h01, 1'b0);
        feat(acp_pkg::FEAT_KEEP_ON_SOFT, 1'b0);
        pulse(1'b0);
        chk("soft kept", {byte_mode, multi_en}, 8'h03);
        feat(acp_pkg::FEAT_RESTORE_ON_SOFT, 1'b0);
        pulse(1'b0);
        chk("soft dflt", {byte_mode, multi_en, multi_count[5:0]}, 8'h00);
        feat(acp_pkg::FEAT_BYTE_ON, 1'b0);
        mult(8'h01, 1'b0);
        pulse(1'b1);
        chk("hw dflt", {byte_mode, multi_en, iois16_en}, 8'h01);
    endtask
    task automatic t_sleep;
        logic [7:0] ops [6] = '{8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94};
        foreach (ops[i]) begin
            cmd(ops[i], 1'b0);
            chk("asleep", asleep, 8'h01);
            feat(acp_pkg::FEAT_NOP_A, 1'b0);
            chk("awake", asleep, 8'h00);
        end
    endtask
    task automatic t_idle;
        int n;
        n = 0;
        while (asleep !== 1'b1 && n < IDLE + 10) begin
            tick();
            n++;
        end
        chk("auto sleep", asleep, 8'h01);
        chk("not early", n >= IDLE - 4, 8'h01);
        chk("no intrq", intrq, 8'h00);
    endtask
    initial begin
        sys_rst = 1'b1;
        soft_rst = 1'b0;
        hw_rst = 1'b0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        tick();
        t_dflt();
        t_feat();
        t_mult();
        t_seek();
        t_resets();
        t_sleep();
        t_idle();
        conclude();
    end
endmodule
`default_nettype wire

// >>> acp_host_model.sv
// host controller model driving the task-file registers
`timescale 1ns/10ps
`default_nettype none
module acp_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // released bus shows garbage, not the last value
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> acp_idle_timer.sv
// idle up-counter that requests sleep after a quiet period
`timescale 1ns/10ps
`default_nettype none
module acp_idle_timer #(
    parameter int IDLE_CYC = acp_pkg::IDLE_SLEEP_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic hold,
    output logic expired
);
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    logic expired_ff;
    logic nxt_expired;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_expired = 1'b0;
        if (restart || hold) begin
            nxt_cnt = 24'h000000;
        end else if (cnt_ff == 24'(IDLE_CYC - 1)) begin
            nxt_expired = 1'b1;
            nxt_cnt = 24'h000000;
        end else begin
            nxt_cnt = cnt_ff + 24'h000001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_ff <= 24'h000000;
            expired_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            expired_ff <= nxt_expired;
        end
    end

    assign expired = expired_ff;
endmodule
`default_nettype wire

// >>> acp_pkg.sv
// constants shared by the configuration and power command handler
`default_nettype none
package acp_pkg;
    // task-file register offsets
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_FEATURE = 3'h1;
    localparam logic [2:0] OFF_COUNT = 3'h2;
    localparam logic [2:0] OFF_SECTOR = 3'h3;
    localparam logic [2:0] OFF_TRK_LO = 3'h4;
    localparam logic [2:0] OFF_TRK_HI = 3'h5;
    localparam logic [2:0] OFF_DRV_HEAD = 3'h6;
    localparam logic [2:0] OFF_OPCODE = 3'h7;
    // read side: status at 7, error at 1, extended error at 0
    localparam logic [2:0] OFF_STATUS = 3'h7;
    localparam logic [2:0] OFF_ERROR = 3'h1;
    localparam logic [2:0] OFF_EXT_ERR = 3'h0;

    // opcodes
    localparam logic [3:0] OPC_SEEK_HI = 4'h7;
    localparam logic [7:0] OPC_SET_FEAT = 8'hef;
    localparam logic [7:0] OPC_SET_MULT = 8'hc6;
    localparam logic [7:0] OPC_SLEEP_A = 8'he6;
    localparam logic [7:0] OPC_SLEEP_B = 8'h99;
    localparam logic [7:0] OPC_STBY_A = 8'he2;
    localparam logic [7:0] OPC_STBY_B = 8'h96;
    localparam logic [7:0] OPC_STBYI_A = 8'he0;
    localparam logic [7:0] OPC_STBYI_B = 8'h94;

    // feature codes
    localparam logic [7:0] FEAT_BYTE_ON = 8'h01;
    localparam logic [7:0] FEAT_LOOKAHEAD_OFF = 8'h55;
    localparam logic [7:0] FEAT_KEEP_ON_SOFT = 8'h66;
    localparam logic [7:0] FEAT_NOP_A = 8'h69;
    localparam logic [7:0] FEAT_BYTE_OFF = 8'h81;
    localparam logic [7:0] FEAT_NOP_B = 8'h96;
    localparam logic [7:0] FEAT_NOP_C = 8'h9a;
    localparam logic [7:0] FEAT_LONG_ECC = 8'hbb;
    localparam logic [7:0] FEAT_RESTORE_ON_SOFT = 8'hcc;

    // status and error bits
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_ERR = 0;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] ERR_IDNF = 8'h10;
    localparam logic [7:0] EXT_NONE = 8'h00;
    localparam logic [7:0] EXT_BAD_ADDR = 8'h21;
    localparam logic [7:0] EXT_ABORTED = 8'h1f;

    // geometry defaults and multi-sector support
    localparam logic [7:0] SUPPORTED_BLOCK = 8'h01;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [3:0] DFLT_HEADS = 4'hf;
    localparam logic [7:0] DFLT_SECTORS = 8'h3f;
    localparam logic [15:0] DFLT_CYLS = 16'h0400;
    localparam logic [27:0] DFLT_LBA_MAX = 28'h00fc000;
    localparam int DRV_LBA_BIT = 6;
    // task-file contents after power-on
    localparam logic [7:0] RST_COUNT = 8'h01;
    localparam logic [7:0] RST_SECTOR = 8'h01;
    localparam logic [7:0] RST_DRV_HEAD = 8'ha0;

    // auto sleep timing
    localparam int CLK_HZ = 20_000_000;
    localparam int IDLE_SLEEP_MS = 5;
    localparam int IDLE_SLEEP_CYC = CLK_HZ / 1000 * IDLE_SLEEP_MS;
    // busy is held this many cycles plus three (seven in all) for non-data commands
    localparam logic [3:0] BUSY_CYC = 4'h4;

    typedef enum logic [2:0] {
        ACP_IDLE,
        ACP_BUSY,
        ACP_EXEC,
        ACP_DONE
    } acp_state_e;
endpackage
`default_nettype wire

// >>> acp_range_chk.sv
// registered range check of a chs or lba address against capacity
`timescale 1ns/10ps
`default_nettype none
module acp_range_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic lba_mode,
    input wire logic [3:0] head,
    input wire logic [15:0] cyl,
    input wire logic [7:0] sector,
    input wire logic [3:0] max_head,
    input wire logic [7:0] max_sector,
    input wire logic [15:0] max_cyl,
    input wire logic [27:0] lba_limit,
    output logic out_of_range
);
    logic out_of_range_ff;
    logic nxt_out_of_range;
    logic [27:0] lba;

    always_comb begin
        lba = {head, cyl, sector};
        if (lba_mode) begin
            nxt_out_of_range = (lba >= lba_limit);
        end else begin
            // chs sectors count from one
            nxt_out_of_range = (head > max_head) || (cyl >= max_cyl)
                || (sector == acp_pkg::ZERO8) || (sector > max_sector);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            out_of_range_ff <= 1'b0;
        end else begin
            out_of_range_ff <= nxt_out_of_range;
        end
    end

    assign out_of_range = out_of_range_ff;
endmodule
`default_nettype wire
